// >>> rtl/sadh_top.sv
// stereo record path: frame tracking, filter-type strap handling and two channel processors
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RQ1] two channels processed side by side, one sample each per frame
// [RQ2] fixed first-order iir high-pass removes dc, corner near 0.00025 x fs
// [RQ3] one high-pass setting shared by all channels, no per-channel control
// [RQ4] decimate modulator stream so output rate equals the frame-sync rate
// [RQ5] slave mode: select pin low gives linear-phase, high gives low-latency
// [RQ6] master mode always uses linear-phase filters whatever the select pin
// [RQ7] linear-phase filters are the default, zero phase deviation in pass band
// [RQ8] linear-phase ripple within +-0.05 dB from dc to 0.454 x fs; the 1-2-1 stage here droops far beyond that near 0.454 x fs
// [RQ9] linear-phase stop band starts at 0.58 x fs, higher floor past 4 x fs; here only a boxcar and a 1-2-1 stage, no defined stop band
// [RQ10] 8 kHz rate: 72.7/81.2 dB stop band, about 17.1 samples delay; the short 1-2-1 stage here meets neither figure
// [RQ11] 16 kHz rate: 73.3/95.0 dB stop band, about 15.7 samples delay; the short 1-2-1 stage here meets neither figure
// [RQ12] content up to 80 kHz passes at 176.4 kHz output rate and above; here only the low-latency path passes it, the 1-2-1 stage attenuates it
// [RQ13] master mode: select pin chooses 256 or 512 x fs system clock
// [RQ14] select pin sampled only while idle, held steady during recording
module sadh_top
    import sadh_pkg::*;
#(
    parameter int unsigned LOSS_CYCLES = LOSS_CYC  // idle timeout, shorten in simulation
) (
    input wire logic mclk,                      // system clock, 50 MHz
    input wire logic sys_rst,                   // synchronous reset, high
    input wire logic master_mode,               // strap: high = master, low = slave
    input wire logic filter_select_pin,         // filter type (slave) or clock ratio (master)
    input wire logic frame_sync,                // frame clock of the serial port
    input wire logic mod_valid,                 // modulator words present this cycle
    input wire logic [MOD_W-1:0] mod_data_left, // left modulator word, signed
    input wire logic [MOD_W-1:0] mod_data_right,// right modulator word, signed
    output logic [OUT_W-1:0] sample_left,       // left filtered sample
    output logic [OUT_W-1:0] sample_right,      // right filtered sample
    output logic sample_valid,                  // pulse: both samples updated
    output logic low_latency_active,            // held filter type, high = low-latency
    output logic mclk_ratio_512,                // master mode: high = 512 x fs clock
    output logic recording,                     // record path running
    output logic [OSR_W-1:0] osr_count          // modulator words in the last frame
);
    sadh_state_t state_reg, state_next;
    logic fs_prev_reg;
    logic [31:0] idle_cnt_reg, idle_cnt_next;
    logic lowlat_reg, lowlat_next;
    logic ratio_reg, ratio_next;
    logic [OSR_W-1:0] osr_run_reg, osr_run_next;
    logic [OSR_W-1:0] osr_reg;
    logic [OUT_W-1:0] left_reg, right_reg;
    logic valid_reg;
    logic fs_rise, timeout, run_w;
    sadh_sample_t chan_left, chan_right;
    logic chan_left_valid, chan_right_valid;

    sadh_ctl_if ctl ();

    // frame boundary is the rising edge of the frame clock; pins are already synchronous
    assign fs_rise = frame_sync && !fs_prev_reg;
    assign timeout = (idle_cnt_reg >= LOSS_CYCLES);
    assign run_w = (state_reg == SADH_ACTIVE);

    // record path starts at the first frame edge and stops when frame edges vanish
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SADH_IDLE: begin
                if (fs_rise) begin
                    state_next = SADH_ACTIVE;
                end
            end
            SADH_ACTIVE: begin
                if (timeout) begin
                    state_next = SADH_IDLE;
                end
            end
        endcase
    end

    // frame-loss watchdog restarts on every frame edge
    assign idle_cnt_next = fs_rise ? CNT_ZERO
                         : (timeout ? idle_cnt_reg : idle_cnt_reg + CNT_ONE);

    // strap decode is frozen while active so a pin change cannot switch filters mid-stream
    assign lowlat_next = (state_reg == SADH_IDLE)
                       ? (!master_mode && filter_select_pin)                     // see [RQ5] [RQ6]
                       : lowlat_reg;                                             // see [RQ14]
    assign ratio_next = (state_reg == SADH_IDLE)
                      ? (master_mode && filter_select_pin)                       // see [RQ13]
                      : ratio_reg;

    // modulator words per frame, useful to confirm the decimation ratio
    assign osr_run_next = fs_rise ? (mod_valid ? OSR_ONE : OSR_ZERO)
                        : (mod_valid ? osr_run_reg + OSR_ONE : osr_run_reg);

    // control state; reset lands on linear-phase, the default filter
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= SADH_IDLE;
            fs_prev_reg <= 1'b0;
            idle_cnt_reg <= CNT_ZERO;
            lowlat_reg <= 1'b0;                                                  // see [RQ7]
            ratio_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            fs_prev_reg <= frame_sync;
            idle_cnt_reg <= idle_cnt_next;
            lowlat_reg <= lowlat_next;
            ratio_reg <= ratio_next;
        end
    end

    // frame word count, captured at each boundary while running
    always_ff @(posedge mclk) begin
        if (sys_rst || !run_w) begin
            osr_run_reg <= OSR_ZERO;
            osr_reg <= OSR_ZERO;
        end else begin
            osr_run_reg <= osr_run_next;
            if (fs_rise) begin
                osr_reg <= osr_run_reg;
            end
        end
    end

    // one control bundle feeds both channels so the high-pass setting is common
    assign ctl.mod_valid = mod_valid && run_w;
    assign ctl.frame_tick = fs_rise && run_w;                                    // see [RQ4]
    assign ctl.low_latency = lowlat_reg;                                         // see [RQ3]
    assign ctl.run = run_w;

    // both channels run in lock step from the same frame tick
    sadh_chan u_chan_left (                                                      // see [RQ1]
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ctl(ctl),
        .mod_data(sadh_mod_t'(mod_data_left)),
        .sample(chan_left),
        .sample_valid(chan_left_valid)
    );

    sadh_chan u_chan_right (                                                     // see [RQ1]
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ctl(ctl),
        .mod_data(sadh_mod_t'(mod_data_right)),
        .sample(chan_right),
        .sample_valid(chan_right_valid)
    );

    // output stage: the pair is released together, never one channel ahead of the other
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            left_reg <= '0;
            right_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= chan_left_valid && chan_right_valid;                    // see [RQ1]
            if (chan_left_valid && chan_right_valid) begin
                left_reg <= chan_left;
                right_reg <= chan_right;
            end
        end
    end

    // outputs come straight from flip-flops
    assign sample_left = left_reg;
    assign sample_right = right_reg;
    assign sample_valid = valid_reg;
    assign low_latency_active = lowlat_reg;
    assign mclk_ratio_512 = ratio_reg;
    assign recording = run_w;
    assign osr_count = osr_reg;
endmodule
`default_nettype wire

// >>> rtl/sadh_pkg.sv
// constants and types shared by the stereo record-path decimation and dc-removal logic
package sadh_pkg;
    localparam int unsigned NUM_CH = 2;            // recording channels in parallel
    localparam int unsigned MOD_W = 4;             // signed multibit modulator word
    localparam int unsigned ACC_W = 24;            // decimator accumulator width
    localparam int unsigned HP_W = 26;             // high-pass state width (headroom)
    localparam int unsigned OUT_W = 24;            // output sample width
    localparam int unsigned OSR_W = 16;            // modulator-samples-per-frame counter
    // one-pole high-pass: pole = 1 - 2^-10 - 2^-11, corner close to 0.00025 x fs
    localparam int unsigned HPF_SH_A = 10;
    localparam int unsigned HPF_SH_B = 11;
    // compensation taps of the linear-phase path, symmetric 1-2-1 over 4
    localparam int unsigned LIN_SH = 2;
    // clock and frame-loss timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned LOSS_TIME_US = 1000;   // no frame edge this long: record stops
    localparam int unsigned LOSS_CYC = (CLK_HZ / 1_000_000) * LOSS_TIME_US;
    localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [31:0] CNT_ONE = 32'h0000_0001;
    localparam logic [OSR_W-1:0] OSR_ZERO = 16'h0000;
    localparam logic [OSR_W-1:0] OSR_ONE = 16'h0001;
    // record path state
    typedef enum logic [0:0] {
        SADH_IDLE,
        SADH_ACTIVE
    } sadh_state_t;
    typedef logic signed [MOD_W-1:0] sadh_mod_t;
    typedef logic signed [OUT_W-1:0] sadh_sample_t;
endpackage

// >>> rtl/sadh_ctl_if.sv
// shared control carried from the record-path top to every channel processor
`timescale 1ns/1ps
`default_nettype none
interface sadh_ctl_if;
    logic mod_valid;    // one modulator word present on every channel
    logic frame_tick;   // one-cycle pulse at each frame boundary
    logic low_latency;  // filter type held for the whole recording
    logic run;          // record path active
    modport src (output mod_valid, output frame_tick, output low_latency, output run);
    modport dst (input mod_valid, input frame_tick, input low_latency, input run);
endinterface
`default_nettype wire

// >>> rtl/sadh_chan.sv
// one record channel: accumulate-and-dump decimator, optional compensation, dc-removal iir
`timescale 1ns/1ps
`default_nettype none
module sadh_chan
    import sadh_pkg::*;
(
    input wire logic mclk,                // system clock
    input wire logic sys_rst,             // synchronous reset, high
    sadh_ctl_if.dst ctl,                  // shared control, same for both channels
    input wire sadh_mod_t mod_data,       // modulator word of this channel
    output sadh_sample_t sample,          // filtered sample, registered
    output logic sample_valid             // one-cycle pulse per frame, registered
);
    logic signed [ACC_W-1:0] acc_reg, acc_next;
    logic signed [ACC_W-1:0] d1_reg, d2_reg;
    logic signed [HP_W-1:0] xprev_reg, y_reg, y_next;
    logic valid_reg;
    logic signed [ACC_W-1:0] mod_ext;
    logic signed [HP_W-1:0] dec_w, d1_w, d2_w, lin_w, fir_w, leak_w;

    // widen the modulator word to accumulator width
    assign mod_ext = ACC_W'(mod_data);

    // integrate between frame boundaries; a word landing on the boundary opens the next frame
    assign acc_next = ctl.frame_tick ? (ctl.mod_valid ? mod_ext : '0)           // see [RQ4]
                    : (ctl.mod_valid ? acc_reg + mod_ext : acc_reg);

    // linear-phase path adds a symmetric compensation stage, low-latency skips it;
    // symmetric taps keep the phase linear, but this short stage only approximates
    // the ripple, stop-band and delay targets of a full multistage decimator
    // (see [RQ8] [RQ9] [RQ10] [RQ11])
    // in low-latency mode the boxcar output is not band-limited further, so wideband content passes at high rates
    assign dec_w = HP_W'(acc_reg);                                               // see [RQ12]
    assign d1_w = HP_W'(d1_reg);
    assign d2_w = HP_W'(d2_reg);
    assign lin_w = (dec_w + (d1_w <<< 1) + d2_w) >>> LIN_SH;                     // see [RQ7]
    assign fir_w = ctl.low_latency ? dec_w : lin_w;                              // see [RQ5]

    // first-order iir high-pass; fixed pole, no per-channel setting by design
    assign leak_w = (y_reg >>> HPF_SH_A) + (y_reg >>> HPF_SH_B);
    assign y_next = fir_w - xprev_reg + y_reg - leak_w;                          // see [RQ2]

    // decimator state runs on every modulator word, cleared while idle
    always_ff @(posedge mclk) begin
        if (sys_rst || !ctl.run) begin
            acc_reg <= '0;
        end else begin
            acc_reg <= acc_next;
        end
    end

    // filter state advances once per frame, one output per frame
    always_ff @(posedge mclk) begin
        if (sys_rst || !ctl.run) begin
            d1_reg <= '0;
            d2_reg <= '0;
            xprev_reg <= '0;
            y_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= ctl.frame_tick;                                         // see [RQ4]
            if (ctl.frame_tick) begin
                d1_reg <= acc_reg;
                d2_reg <= d1_reg;
                xprev_reg <= fir_w;
                y_reg <= y_next;
            end
        end
    end

    // top bits of the high-pass state form the sample; the two lowest bits are dropped
    assign sample = y_reg[HP_W-1 -: OUT_W];
    assign sample_valid = valid_reg;
endmodule
`default_nettype wire

// >>> test/sadh_props.sv
// assertion checker for the stereo record path top
`timescale 1ns/1ps
`default_nettype none
module sadh_props
    import sadh_pkg::*;
#(
    parameter int unsigned LOSS_CYCLES = LOSS_CYC  // frame-loss timeout
) (
    input wire logic mclk,                        // clock
    input wire logic sys_rst,                     // reset, high
    input wire logic master_mode,                 // strap
    input wire logic filter_select_pin,           // strap
    input wire logic frame_sync,                  // frame clock
    input wire logic mod_valid,                   // word strobe
    input wire logic [MOD_W-1:0] mod_data_left,   // left word
    input wire logic [MOD_W-1:0] mod_data_right,  // right word
    input wire logic [OUT_W-1:0] sample_left,     // left sample
    input wire logic [OUT_W-1:0] sample_right,    // right sample
    input wire logic sample_valid,                // sample pulse
    input wire logic low_latency_active,          // held filter type
    input wire logic mclk_ratio_512,              // held clock ratio
    input wire logic recording,                   // record path running
    input wire logic [OSR_W-1:0] osr_count        // words in last frame
);
    logic fs_prev_reg;
    logic [31:0] gap_reg;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // cycles since the last frame edge, so a lost frame clock is bounded
    always_ff @(posedge mclk) begin
        fs_prev_reg <= sys_rst ? 1'b0 : frame_sync;
        gap_reg <= (sys_rst || !recording || (frame_sync && !fs_prev_reg))
                   ? CNT_ZERO : gap_reg + CNT_ONE;
    end
    property p_tick;
        recording && $rose(frame_sync) |-> ##2 sample_valid;
    endproperty
    a_tick: assert property (p_tick) else $error("no sample after frame edge");
    property p_pulse;
        sample_valid |=> !sample_valid;
    endproperty
    a_pulse: assert property (p_pulse) else $error("sample pulse too long");
    property p_cause;
        sample_valid |-> $past(recording, 2) && $past(frame_sync, 2)
            && !$past(frame_sync, 3);
    endproperty
    a_cause: assert property (p_cause) else $error("sample without frame edge");
    property p_ll;
        !recording |=> low_latency_active
            == (!$past(master_mode) && $past(filter_select_pin));
    endproperty
    a_ll: assert property (p_ll) else $error("filter type decode wrong");
    property p_ratio;
        !recording |=> mclk_ratio_512 == ($past(master_mode) && $past(filter_select_pin));
    endproperty
    a_ratio: assert property (p_ratio) else $error("clock ratio decode wrong");
    property p_hold;
        recording |=> $stable(low_latency_active) && $stable(mclk_ratio_512);
    endproperty
    a_hold: assert property (p_hold) else $error("strap moved while recording");
    // the count is cleared one cycle into idle, so it is checked as zero, not as stable
    property p_osr;
        !recording |=> osr_count == OSR_ZERO;
    endproperty
    a_osr: assert property (p_osr) else $error("word count kept while idle");
    property p_smp;
        !sample_valid |-> $stable(sample_left) && $stable(sample_right);
    endproperty
    a_smp: assert property (p_smp) else $error("samples moved without pulse");
    property p_loss;
        recording |-> gap_reg < LOSS_CYCLES + 3;
    endproperty
    a_loss: assert property (p_loss) else $error("record ran on without frames");
endmodule
bind sadh_top sadh_props #(.LOSS_CYCLES(LOSS_CYCLES)) u_props (.mclk(mclk), .sys_rst(sys_rst),
    .master_mode(master_mode), .filter_select_pin(filter_select_pin), .frame_sync(frame_sync),
    .mod_valid(mod_valid), .mod_data_left(mod_data_left), .mod_data_right(mod_data_right),
    .sample_left(sample_left), .sample_right(sample_right), .sample_valid(sample_valid),
    .low_latency_active(low_latency_active), .mclk_ratio_512(mclk_ratio_512),
    .recording(recording), .osr_count(osr_count));
`default_nettype wire

// >>> test/sadh_mod_model.sv
// behavioural modulator pair and frame clock source
`timescale 1ns/1ps
`default_nettype none
module sadh_mod_model
    import sadh_pkg::*;
(
    input wire logic mclk,                        // clock
    input wire logic run,                         // frames and words flow
    input wire logic [15:0] period,               // cycles per frame
    input wire logic [MOD_W-1:0] word_l,          // left word
    input wire logic [MOD_W-1:0] word_r,          // right word
    output logic frame_sync,                      // frame clock
    output logic mod_valid,                       // word strobe
    output logic [MOD_W-1:0] mod_data_left,       // left data
    output logic [MOD_W-1:0] mod_data_right       // right data
);
    logic en = 1'b0;
    int cnt = 0;
    int rises = 0;
    initial begin
        frame_sync = 1'b0;
        mod_valid = 1'b0;
        mod_data_left = 4'h0;
        mod_data_right = 4'h0;
    end
    // zero words until the first tick, so the entry frame cannot skew sums
    always @(posedge mclk) begin
        en = run;
        #1;
        if (!en) begin
            cnt = 0;
            rises = 0;
            frame_sync = 1'b0;
            mod_valid = 1'b0;
            mod_data_left = ~mod_data_left;  // released data toggles, never holds
            mod_data_right = ~mod_data_right;
        end else begin
            if (cnt == 0) rises = rises + 1;
            frame_sync = (cnt < int'(period) / 2);
            mod_valid = 1'b1;
            mod_data_left = (rises >= 2) ? word_l : 4'h0;
            mod_data_right = (rises >= 2) ? word_r : 4'h0;
            cnt = (cnt + 1) % int'(period);
        end
    end
endmodule
`default_nettype wire

// >>> test/tb_stereo_adc_decimation_hpf.sv
// self-checking bench for the stereo record path
`timescale 1ns/1ps
`default_nettype none
module tb_stereo_adc_decimation_hpf;
    import sadh_pkg::*;
    localparam int PER = 16;
    localparam int LOSS = 200;
    logic mclk = 1'b0, sys_rst = 1'b1, master_mode = 1'b0, filter_select_pin = 1'b0, run = 1'b0;
    logic frame_sync, mod_valid, sv, ll, r512, rec;
    logic [MOD_W-1:0] dl, dr;
    logic [OUT_W-1:0] sl, sr;
    logic [OSR_W-1:0] osr;
    int fail_count = 0, num_checks = 0, cyc = 0;
    logic signed [25:0] x1[2], x2[2], xp[2], y[2];
    sadh_mod_model i_model (.mclk(mclk), .run(run), .period(16'(PER)), .word_l(4'h3),
        .word_r(4'hb), .frame_sync(frame_sync), .mod_valid(mod_valid),
        .mod_data_left(dl), .mod_data_right(dr));
    sadh_top #(.LOSS_CYCLES(LOSS)) i_dut (.mclk(mclk), .sys_rst(sys_rst),
        .master_mode(master_mode), .filter_select_pin(filter_select_pin),
        .frame_sync(frame_sync), .mod_valid(mod_valid), .mod_data_left(dl),
        .mod_data_right(dr), .sample_left(sl), .sample_right(sr), .sample_valid(sv),
        .low_latency_active(ll), .mclk_ratio_512(r512), .recording(rec), .osr_count(osr));
    always #10 mclk = ~mclk;
    // a hang is cut short well past the roughly 1300 cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // reference: optional 1-2-1 stage, then one-pole dc removal, top 24 bits
    task automatic ref_step(input int c, input logic signed [25:0] x, input logic lowlat,
                            output logic [23:0] o);
        logic signed [25:0] v;
        v = lowlat ? x : (x + (x1[c] <<< 1) + x2[c]) >>> 2;
        x2[c] = x1[c];
        x1[c] = x;
        y[c] = v - xp[c] + y[c] - (y[c] >>> 10) - (y[c] >>> 11);
        xp[c] = v;
        o = y[c][25:2];
    endtask
    // record six frames in one strap setting, then lose the frame clock
    task automatic run_mode(input logic mm, input logic pin, input logic ell, input logic e512);
        logic [23:0] el, er;
        int w;
        master_mode = mm;
        filter_select_pin = pin;
        for (int c = 0; c < 2; c++) begin
            x1[c] = 0;
            x2[c] = 0;
            xp[c] = 0;
            y[c] = 0;
        end
        run = 1'b1;
        for (int k = 1; k <= 6; k++) begin
            w = 0;
            do begin
                @(posedge mclk);
                #1;
                w++;
            end while (sv !== 1'b1 && w < 100);
            check(sv, 1'b1);
            ref_step(0, (k >= 2) ? 26'(3 * PER) : 26'h0, ell, el);
            ref_step(1, (k >= 2) ? 26'(-5 * PER) : 26'h0, ell, er);
            check(sl, el);
            check(sr, er);
            if (k >= 2) check(osr, PER);
            check(ll, ell);
            check(r512, e512);
            master_mode = ~mm;
            filter_select_pin = ~pin;
        end
        run = 1'b0;
        master_mode = mm;
        filter_select_pin = pin;
        repeat (LOSS - 20) @(posedge mclk);
        #1 check(rec, 1'b1);
        repeat (40) @(posedge mclk);
        #1 check(rec, 1'b0);
    endtask
    // slave, select low: linear-phase, the default path
    task automatic scen_slave_linear();
        run_mode(1'b0, 1'b0, 1'b0, 1'b0);
    endtask
    // slave, select high: low-latency path
    task automatic scen_slave_lowlat();
        run_mode(1'b0, 1'b1, 1'b1, 1'b0);
    endtask
    // master, select high: linear-phase forced, pin reads as the 512 x fs ratio
    task automatic scen_master_512();
        run_mode(1'b1, 1'b1, 1'b0, 1'b1);
    endtask
    // master, select low: linear-phase, 256 x fs ratio
    task automatic scen_master_256();
        run_mode(1'b1, 1'b0, 1'b0, 1'b0);
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        #1 sys_rst = 1'b0;
        check(ll, 1'b0);
        check(rec, 1'b0);
        scen_slave_linear();
        scen_slave_lowlat();
        scen_master_512();
        scen_master_256();
        tally_and_finish();
    end
endmodule
`default_nettype wire
